// ---- core/lpm_clk_div.sv ----
// Programmable clock divider producing a one-cycle enable tick.
// Assumes the select comes from logic on the same clock.
module lpm_clk_div
	import lpm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [DIV_SEL_W-1:0] sel_i,
	output logic tick_o
);

	logic [DIV_CNT_W-1:0] cnt_q;
	logic [DIV_CNT_W-1:0] cnt_d;
	logic [DIV_SEL_W-1:0] sel_lim;
	logic [6:0] ratio;
	logic wrap;

	// Prohibited codes clamp to the slowest ratio rather than overflow.
	assign sel_lim = (sel_i > DIV_SEL_MAX) ? DIV_SEL_MAX : sel_i;
	assign ratio = DIV_ONE << sel_lim;
	assign wrap = (cnt_q == '0);
	assign cnt_d = wrap ? DIV_CNT_W'(ratio - DIV_ONE) : cnt_q - 1'b1;

	// The counter reloads on every wrap, so a new ratio takes hold then.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cnt_q <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_o <= wrap;
		end
	end

	AST_DIV_ONE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R01
		(sel_i == 4'h0) ##1 tick_o |=> tick_o)
		else $error("divide-by-one divider did not tick every cycle");

endmodule

// ---- core/lpm_low_power_ctrl.sv ----
// Low-power control: clock dividers, clock pins, module stops, power modes,
// deep standby power cut, deep wake pins and voltage-monitor reset flags.
// Assumes software-driven level ports from same-clock logic and async pins.

// Contract
// R01 - Each system, peripheral, bus and flash clock has its own divider.
// R02 - Bus clock pin carries the running clock or constant high.
// R03 - Memory clock pin carries the running clock or constant high.
// R04 - Every peripheral has its own separate module-stop control.
// R05 - Sleep, all-module stop, software standby and deep standby are supported.
// R06 - High-speed, low-speed 1 and low-speed 2; both low modes equal.
// R07 - Deep cut 00 keep, 01 off, 10 prohibited, 11 off plus detector stop.
// R08 - Stop A: timer W unit 1 bit 0, unit 0 bit 1, pulse unit bit 13.
// R09 - Stop A: converter unit 1 bit 16, unit 0 bit 17, DAC neighbour.
// R10 - Stop B: data operation bit 6, temperature bit 8, event link bit 9.
// R11 - Stop B: capture bit 22, serial 7 bit 24, serial 4 bit 27.
// R12 - Stop C: standby RAM 7, second two-wire 17, clock checker 19.
// R13 - Four deep wake pins each have enable and release flag.
// R14 - Edge select bits 4 to 7 pick each wake pin's trigger edge.
// R15 - Reset cause bits 1, 2, 3 record voltage monitor 0, 1, 2 resets.
// R16 - Software waits two network clocks after network stop change before wait.
// R17 - Stop bit one gates peripheral clock; zero restores it.
module lpm_low_power_ctrl
	import lpm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [DIV_SEL_W-1:0] system_clock_sel_i,
	input wire logic [DIV_SEL_W-1:0] periph_clock_a_sel_i,
	input wire logic [DIV_SEL_W-1:0] periph_clock_b_sel_i,
	input wire logic [DIV_SEL_W-1:0] periph_clock_c_sel_i,
	input wire logic [DIV_SEL_W-1:0] periph_clock_d_sel_i,
	input wire logic [DIV_SEL_W-1:0] bus_clock_sel_i,
	input wire logic [DIV_SEL_W-1:0] flash_if_clock_sel_i,
	input wire logic bus_clk_hold_high_i,
	input wire logic sync_mem_clk_hold_high_i,
	input wire logic [MSTP_W-1:0] module_stop_ctrl_a_i,
	input wire logic [MSTP_W-1:0] module_stop_ctrl_b_i,
	input wire logic [MSTP_W-1:0] module_stop_ctrl_c_i,
	input wire logic [1:0] lp_mode_sel_i,
	input wire logic wait_exec_i,
	input wire logic wake_irq_i,
	input wire logic [1:0] op_power_ctrl_i,
	input wire logic [1:0] deep_power_cut_i,
	input wire logic [WAKE_REG_W-1:0] deep_wake_enable_0_i,
	input wire logic [WAKE_REG_W-1:0] deep_wake_edge_0_i,
	input wire logic [WAKE_REG_W-1:0] deep_wake_flag_clr_i,
	input wire logic [WAKE_PINS-1:0] deep_wake_pin_i,
	input wire logic [2:0] vmon_reset_i,
	input wire logic [RC_W-1:0] reset_cause_clr_i,
	output logic system_clock_tick_o,
	output logic periph_clock_a_tick_o,
	output logic periph_clock_b_tick_o,
	output logic periph_clock_c_tick_o,
	output logic periph_clock_d_tick_o,
	output logic bus_clock_tick_o,
	output logic flash_if_clock_tick_o,
	output logic bus_clk_pin_o,
	output logic sync_mem_clock_pin_o,
	output logic [MSTP_W-1:0] periph_clk_en_a_o,
	output logic [MSTP_W-1:0] periph_clk_en_b_o,
	output logic [MSTP_W-1:0] periph_clk_en_c_o,
	output logic [2:0] lp_state_o,
	output logic cpu_halt_o,
	output logic periph_halt_o,
	output logic osc_stop_o,
	output logic deep_release_o,
	output logic [1:0] op_power_mode_o,
	output logic op_low_speed_o,
	output logic [1:0] deep_power_cut_o,
	output logic stby_ram_power_off_o,
	output logic vdet_stop_o,
	output logic por_low_power_o,
	output logic [WAKE_REG_W-1:0] deep_wake_flag_0_o,
	output logic [RC_W-1:0] reset_cause_status_o
);

	lpm_state_t state_q;
	lpm_state_t state_d;
	logic [MSTP_W-1:0] mstp_a_q;
	logic [MSTP_W-1:0] mstp_b_q;
	logic [MSTP_W-1:0] mstp_c_q;
	logic [1:0] cut_q;
	logic [1:0] cut_d;
	logic [1:0] opm_q;
	logic [1:0] opm_d;
	logic [WAKE_REG_W-1:0] flag_d;
	logic [WAKE_REG_W-1:0] flag_set;
	logic [WAKE_PINS-1:0] pin_edge;
	logic [RC_W-1:0] rc_set;
	logic [RC_W-1:0] rc_d;
	logic in_deep;
	logic halt_periph;
	logic stop_osc;
	logic bus_pin_d;
	logic mem_pin_d;
	logic opm_valid;
	logic deep_exit;

	// One divider per clock, each with its own ratio select.
	lpm_clk_div u_div_sys (.clk_i(clk_i), .rst_b_i(rst_b_i), // R01
		.sel_i(system_clock_sel_i), .tick_o(system_clock_tick_o));
	lpm_clk_div u_div_pa (.clk_i(clk_i), .rst_b_i(rst_b_i), // R01
		.sel_i(periph_clock_a_sel_i), .tick_o(periph_clock_a_tick_o));
	lpm_clk_div u_div_pb (.clk_i(clk_i), .rst_b_i(rst_b_i), // R01
		.sel_i(periph_clock_b_sel_i), .tick_o(periph_clock_b_tick_o));
	lpm_clk_div u_div_pc (.clk_i(clk_i), .rst_b_i(rst_b_i), // R01
		.sel_i(periph_clock_c_sel_i), .tick_o(periph_clock_c_tick_o));
	lpm_clk_div u_div_pd (.clk_i(clk_i), .rst_b_i(rst_b_i), // R01
		.sel_i(periph_clock_d_sel_i), .tick_o(periph_clock_d_tick_o));
	lpm_clk_div u_div_bus (.clk_i(clk_i), .rst_b_i(rst_b_i), // R01
		.sel_i(bus_clock_sel_i), .tick_o(bus_clock_tick_o));
	lpm_clk_div u_div_fl (.clk_i(clk_i), .rst_b_i(rst_b_i), // R01
		.sel_i(flash_if_clock_sel_i), .tick_o(flash_if_clock_tick_o));

	// One synchroniser and edge detector per deep wake pin.
	for (genvar i = 0; i < WAKE_PINS; i++) begin : g_wake
		lpm_wake_pin u_pin (
			.clk_i(clk_i),
			.rst_b_i(rst_b_i),
			.pin_i(deep_wake_pin_i[i]),
			.rise_sel_i(deep_wake_edge_0_i[WAKE_LO_BIT+i]), // R14
			.edge_o(pin_edge[i])
		);
	end

	// Pin edges only count in deep standby and only where enabled.
	assign in_deep = (state_q == LPM_DEEP);
	assign flag_set = {pin_edge, 4'h0} & deep_wake_enable_0_i
		& {WAKE_REG_W{in_deep}}; // R13
	assign flag_d = (deep_wake_flag_0_o & ~deep_wake_flag_clr_i) | flag_set;
	assign deep_exit = |flag_set; // R13

	// Mode sequencing: a wait enters the chosen mode, a wake returns to run.
	always_comb begin
		state_d = state_q;
		case (state_q)
			LPM_RUN: begin
				if (wait_exec_i) begin
					case (lpm_sel_t'(lp_mode_sel_i))
						LPM_SEL_SLEEP: state_d = LPM_SLEEP; // R05
						LPM_SEL_ALLSTOP: state_d = LPM_ALLSTOP; // R05
						LPM_SEL_SWSTBY: state_d = LPM_SWSTBY; // R05
						default: state_d = LPM_DEEP; // R05
					endcase
				end
			end
			LPM_SLEEP, LPM_ALLSTOP, LPM_SWSTBY: begin
				if (wake_irq_i) begin
					state_d = LPM_RUN;
				end
			end
			LPM_DEEP: begin
				if (deep_exit) begin
					state_d = LPM_RUN;
				end
			end
			default: state_d = LPM_RUN;
		endcase
	end

	// Which resources each state stops.
	assign halt_periph = (state_d == LPM_ALLSTOP) || (state_d == LPM_SWSTBY)
		|| (state_d == LPM_DEEP);
	assign stop_osc = (state_d == LPM_SWSTBY) || (state_d == LPM_DEEP);

	// The prohibited cut code is dropped so the field keeps a legal value.
	assign cut_d = (deep_power_cut_i == CUT_PROHIB) ? cut_q
		: deep_power_cut_i; // R07
	// Code three is not a mode and leaves the current one in place.
	assign opm_valid = (op_power_ctrl_i != 2'h3);
	assign opm_d = opm_valid ? op_power_ctrl_i : opm_q; // R06

	// Clock pins toggle on bus ticks, forced high when held or stopped.
	assign bus_pin_d = (bus_clk_hold_high_i || stop_osc) ? 1'b1
		: (bus_clock_tick_o ? ~bus_clk_pin_o : bus_clk_pin_o); // R02
	assign mem_pin_d = (sync_mem_clk_hold_high_i || stop_osc) ? 1'b1
		: (bus_clock_tick_o ? ~sync_mem_clock_pin_o
		: sync_mem_clock_pin_o); // R03

	// Voltage monitor resets set their cause flag; a set beats a clear.
	assign rc_set = {4'h0, vmon_reset_i, 1'b0}; // R15
	assign rc_d = (reset_cause_status_o & ~reset_cause_clr_i) | rc_set;

	// State, control captures and status flags.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_q <= LPM_RUN;
			cut_q <= CUT_RST;
			opm_q <= OPM_RST;
			deep_wake_flag_0_o <= WAKE_RST;
			reset_cause_status_o <= RC_RST;
		end else begin
			state_q <= state_d;
			cut_q <= cut_d;
			opm_q <= opm_d;
			deep_wake_flag_0_o <= flag_d;
			reset_cause_status_o <= rc_d;
		end
	end

	// Module-stop registers: each bit belongs to one peripheral alone.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			mstp_a_q <= MSTP_RST;
			mstp_b_q <= MSTP_RST;
			mstp_c_q <= MSTP_RST;
		end else begin
			mstp_a_q <= module_stop_ctrl_a_i; // R04
			mstp_b_q <= module_stop_ctrl_b_i; // R04
			mstp_c_q <= module_stop_ctrl_c_i; // R04
		end
	end

	// Clock enables: a stop bit or a deep enough mode removes the clock.
	// Enables lag the stop bit by one cycle, so a change settles in two.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			periph_clk_en_a_o <= '0;
			periph_clk_en_b_o <= '0;
			periph_clk_en_c_o <= '0;
		end else begin
			periph_clk_en_a_o <= ~mstp_a_q & {MSTP_W{~halt_periph}}; // R17
			periph_clk_en_b_o <= ~mstp_b_q & {MSTP_W{~halt_periph}}; // R17
			periph_clk_en_c_o <= ~mstp_c_q & {MSTP_W{~halt_periph}}; // R17
		end
	end

	// Registered status and power outputs for the next state.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			lp_state_o <= LPM_RUN;
			cpu_halt_o <= 1'b0;
			periph_halt_o <= 1'b0;
			osc_stop_o <= 1'b0;
			deep_release_o <= 1'b0;
			op_power_mode_o <= OPM_RST;
			op_low_speed_o <= 1'b0;
			deep_power_cut_o <= CUT_RST;
			stby_ram_power_off_o <= 1'b0;
			vdet_stop_o <= 1'b0;
			por_low_power_o <= 1'b0;
			bus_clk_pin_o <= 1'b1;
			sync_mem_clock_pin_o <= 1'b1;
		end else begin
			lp_state_o <= state_d;
			cpu_halt_o <= (state_d != LPM_RUN); // R05
			periph_halt_o <= halt_periph; // R05
			osc_stop_o <= stop_osc; // R05
			deep_release_o <= in_deep && deep_exit;
			op_power_mode_o <= opm_d;
			// Both low-speed modes drive the same regulator setting.
			op_low_speed_o <= (opm_d != LPM_OPM_HIGH); // R06
			deep_power_cut_o <= cut_d;
			stby_ram_power_off_o <= (state_d == LPM_DEEP) && cut_d[0]; // R07
			vdet_stop_o <= (state_d == LPM_DEEP) && (cut_d == CUT_FULL); // R07
			por_low_power_o <= (state_d == LPM_DEEP) && (cut_d == CUT_FULL);
			bus_clk_pin_o <= bus_pin_d;
			sync_mem_clock_pin_o <= mem_pin_d;
		end
	end

	AST_SLEEP_ENTRY: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R05
		(lp_state_o == LPM_RUN) && wait_exec_i && (lp_mode_sel_i == 2'h0)
		|=> (lp_state_o == LPM_SLEEP) && cpu_halt_o && !periph_halt_o)
		else $error("wait with sleep selected did not enter sleep");
	AST_DEEP_ENTRY: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R05
		(lp_state_o == LPM_RUN) && wait_exec_i && (lp_mode_sel_i == 2'h3)
		|=> (lp_state_o == LPM_DEEP) && osc_stop_o)
		else $error("wait with deep selected did not enter deep standby");
	AST_OPM_LOW: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R06
		(op_power_ctrl_i == 2'h1) || (op_power_ctrl_i == 2'h2)
		|=> op_low_speed_o && (op_power_mode_o == $past(op_power_ctrl_i)))
		else $error("low-speed mode not reported as low speed");
	AST_CUT_PROHIB: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R07
		deep_power_cut_i == 2'h2 |=> $stable(deep_power_cut_o))
		else $error("prohibited deep cut value was accepted");
	AST_VDET_STOP: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R07
		vdet_stop_o |-> (deep_power_cut_o == 2'h3) && (lp_state_o == LPM_DEEP)
		&& stby_ram_power_off_o)
		else $error("detector stopped outside full deep cut");
	AST_BUS_PIN_HIGH: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R02
		bus_clk_hold_high_i |=> bus_clk_pin_o)
		else $error("bus clock pin not high while held");
	AST_BUS_PIN_RUN: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R02
		!bus_clk_hold_high_i && !osc_stop_o && !stop_osc && bus_clock_tick_o
		|=> bus_clk_pin_o != $past(bus_clk_pin_o))
		else $error("bus clock pin did not toggle on a bus tick");
	AST_MEM_PIN_HIGH: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R03
		sync_mem_clk_hold_high_i |=> sync_mem_clock_pin_o)
		else $error("memory clock pin not high while held");
	AST_STOP_A: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R08
		module_stop_ctrl_a_i[MSTPA_TPU0] |=> ##1 !periph_clk_en_a_o[MSTPA_TPU0])
		else $error("pulse unit clock not gated by its stop bit");
	AST_STOP_A_ADC: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R09
		!module_stop_ctrl_a_i[MSTPA_ADC1] && !halt_periph && !periph_halt_o
		|=> ##1 periph_clk_en_a_o[MSTPA_ADC1] || periph_halt_o)
		else $error("converter unit 1 clock not restored");
	AST_STOP_B: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R10
		module_stop_ctrl_b_i[MSTPB_ELC] |=> ##1 !periph_clk_en_b_o[MSTPB_ELC])
		else $error("event link clock not gated by its stop bit");
	AST_STOP_B_SCI: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R11
		module_stop_ctrl_b_i[MSTPB_SCI4] |=> ##1 !periph_clk_en_b_o[MSTPB_SCI4])
		else $error("serial 4 clock not gated by its stop bit");
	AST_STOP_C: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
		module_stop_ctrl_c_i[MSTPC_SRAM] |=> ##1 !periph_clk_en_c_o[MSTPC_SRAM])
		else $error("standby RAM clock not gated by its stop bit");
	AST_WAKE_FLAG: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R13
		in_deep && pin_edge[0] && deep_wake_enable_0_i[WAKE_LO_BIT]
		|=> deep_wake_flag_0_o[WAKE_LO_BIT] && deep_release_o
		&& (lp_state_o == LPM_RUN))
		else $error("enabled wake pin did not set flag and release");
	AST_WAKE_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R13
		!in_deep |=> deep_wake_flag_0_o[7:4]
		== ($past(deep_wake_flag_0_o[7:4]) & ~$past(deep_wake_flag_clr_i[7:4])))
		else $error("wake flag set outside deep standby");
	AST_VMON_FLAG: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R15
		vmon_reset_i[0] |=> reset_cause_status_o[RC_VMON0])
		else $error("monitor 0 reset not recorded even against a clear");

endmodule

// ---- core/lpm_pkg.sv ----
// Constants and types shared by the low-power control block.
// Assumes one system clock and a synchronous active-low chip reset.
package lpm_pkg;

	// Division select codes: code n divides by 2**n, codes above six are clamped to six.
	localparam int DIV_SEL_W = 4;
	localparam int DIV_CNT_W = 6;
	localparam logic [3:0] DIV_SEL_MAX = 4'h6;
	localparam logic [3:0] DIV_SEL_RST = 4'h0;
	localparam logic [6:0] DIV_ONE = 7'h01;

	// Module-stop registers, every module stopped after reset.
	localparam int MSTP_W = 32;
	localparam logic [31:0] MSTP_RST = 32'hFFFFFFFF;
	localparam int MSTPA_CMTW1 = 0;
	localparam int MSTPA_CMTW0 = 1;
	localparam int MSTPA_TPU0 = 13;
	localparam int MSTPA_ADC1 = 16;
	localparam int MSTPA_ADC0 = 17;
	localparam int MSTPA_DAC = 19;
	localparam int MSTPB_CAN0 = 0;
	localparam int MSTPB_CAN1 = 1;
	localparam int MSTPB_DOC = 6;
	localparam int MSTPB_TEMP = 8;
	localparam int MSTPB_ELC = 9;
	localparam int MSTPB_PDC = 22;
	localparam int MSTPB_SCI7 = 24;
	localparam int MSTPB_SCI4 = 27;
	localparam int MSTPC_SRAM = 7;
	localparam int MSTPC_IIC2 = 17;
	localparam int MSTPC_CLKCHK = 19;
	localparam int MSTPC_SER_LO = 22;
	localparam int MSTPC_SER_HI = 27;

	// Deep power cut field values.
	localparam logic [1:0] CUT_KEEP = 2'h0;
	localparam logic [1:0] CUT_RAM_OFF = 2'h1;
	localparam logic [1:0] CUT_PROHIB = 2'h2;
	localparam logic [1:0] CUT_FULL = 2'h3;
	localparam logic [1:0] CUT_RST = 2'h0;

	// Deep wake registers: pins sit at bits 4 to 7 of each 8-bit register.
	localparam int WAKE_REG_W = 8;
	localparam int WAKE_PINS = 4;
	localparam int WAKE_LO_BIT = 4;
	localparam logic [7:0] WAKE_RST = 8'h00;

	// Reset cause flags for voltage monitors 0, 1 and 2.
	localparam int RC_W = 8;
	localparam int RC_VMON0 = 1;
	localparam int RC_VMON1 = 2;
	localparam int RC_VMON2 = 3;
	localparam logic [7:0] RC_RST = 8'h00;

	// Low-power mode chosen for the next wait instruction.
	typedef enum logic [1:0] {
		LPM_SEL_SLEEP = 2'h0,
		LPM_SEL_ALLSTOP = 2'h1,
		LPM_SEL_SWSTBY = 2'h2,
		LPM_SEL_DEEP = 2'h3
	} lpm_sel_t;

	// Power state, Gray coded along run, sleep, all-stop, standby, deep.
	typedef enum logic [2:0] {
		LPM_RUN = 3'h0,
		LPM_SLEEP = 3'h1,
		LPM_ALLSTOP = 3'h3,
		LPM_SWSTBY = 3'h2,
		LPM_DEEP = 3'h6
	} lpm_state_t;

	// Operating power control modes; code three is not a mode.
	typedef enum logic [1:0] {
		LPM_OPM_HIGH = 2'h0,
		LPM_OPM_LOW1 = 2'h1,
		LPM_OPM_LOW2 = 2'h2
	} lpm_opm_t;
	localparam logic [1:0] OPM_RST = 2'h0;

endpackage

// ---- core/lpm_wake_pin.sv ----
// Synchroniser and selectable edge detector for one deep wake pin.
// Assumes the pin is asynchronous to the system clock.
module lpm_wake_pin
	import lpm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic pin_i,
	input wire logic rise_sel_i,
	output logic edge_o
);

	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic seen;
	logic [2:0] arm_q;

	// Edge select: one picks a rising edge, zero a falling edge.
	assign seen = rise_sel_i ? (sync2_q & ~prev_q) : (~sync2_q & prev_q); // R14

	// Two stages before any logic looks at the pin.
	// The zeros loaded by reset are not real samples, so edges are held off
	// until the pipeline holds the pin; a pin idling high gives no false edge.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
			arm_q <= 3'h0;
			edge_o <= 1'b0;
		end else begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			arm_q <= {arm_q[1:0], 1'b1};
			edge_o <= seen & arm_q[2];
		end
	end

endmodule

// ---- tb/tb.sv ----
// Self-checking testbench for the low-power control block.
// Assumes the block is driven only through its level ports by this bench.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lpm_pkg::*;

	// Stimulus registers, all given a value at time zero.
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [3:0] sel [7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
	logic bus_hh = 1'b0, mem_hh = 1'b0, wait_x = 1'b0, wake = 1'b0;
	logic [31:0] stp [3] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
	logic [1:0] mode_sel = 2'h0, opm = 2'h0, cut = 2'h0;
	logic [7:0] wen = 8'h00, wedge = 8'h50, wclr = 8'h00, rclr = 8'h00;
	logic [3:0] wpin = 4'hA;
	logic [2:0] vmon = 3'h0;
	// Observed outputs.
	logic [6:0] tk;
	logic bus_pin, mem_pin, cpu_h, per_h, osc_s, rel, low_o;
	logic ram_off, vdet, por_lp;
	logic [31:0] en [3];
	logic [2:0] st;
	logic [1:0] opm_o, cut_o;
	logic [7:0] wflag, rcause;
	int errors = 0;
	int check_count = 0;
	int cnt [7];
	int tog_b, tog_m, k;
	logic pb, pm;
	int bits [14] = '{0, 1, 13, 16, 17, 6, 8, 9, 22, 24, 27, 7, 17, 19};
	int regs [14] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 2, 2, 2};

	lpm_low_power_ctrl DUT (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.system_clock_sel_i(sel[0]), .periph_clock_a_sel_i(sel[1]),
		.periph_clock_b_sel_i(sel[2]), .periph_clock_c_sel_i(sel[3]),
		.periph_clock_d_sel_i(sel[4]), .bus_clock_sel_i(sel[5]),
		.flash_if_clock_sel_i(sel[6]), .bus_clk_hold_high_i(bus_hh),
		.sync_mem_clk_hold_high_i(mem_hh), .module_stop_ctrl_a_i(stp[0]),
		.module_stop_ctrl_b_i(stp[1]), .module_stop_ctrl_c_i(stp[2]),
		.lp_mode_sel_i(mode_sel), .wait_exec_i(wait_x), .wake_irq_i(wake),
		.op_power_ctrl_i(opm), .deep_power_cut_i(cut),
		.deep_wake_enable_0_i(wen), .deep_wake_edge_0_i(wedge),
		.deep_wake_flag_clr_i(wclr), .deep_wake_pin_i(wpin),
		.vmon_reset_i(vmon), .reset_cause_clr_i(rclr),
		.system_clock_tick_o(tk[0]), .periph_clock_a_tick_o(tk[1]),
		.periph_clock_b_tick_o(tk[2]), .periph_clock_c_tick_o(tk[3]),
		.periph_clock_d_tick_o(tk[4]), .bus_clock_tick_o(tk[5]),
		.flash_if_clock_tick_o(tk[6]), .bus_clk_pin_o(bus_pin),
		.sync_mem_clock_pin_o(mem_pin), .periph_clk_en_a_o(en[0]),
		.periph_clk_en_b_o(en[1]), .periph_clk_en_c_o(en[2]),
		.lp_state_o(st), .cpu_halt_o(cpu_h), .periph_halt_o(per_h),
		.osc_stop_o(osc_s), .deep_release_o(rel), .op_power_mode_o(opm_o),
		.op_low_speed_o(low_o), .deep_power_cut_o(cut_o),
		.stby_ram_power_off_o(ram_off), .vdet_stop_o(vdet),
		.por_low_power_o(por_lp), .deep_wake_flag_0_o(wflag),
		.reset_cause_status_o(rcause));

	// Free-running 50 MHz system clock.
	initial begin
		forever #10 clk_i = ~clk_i;
	end

	// Compares one value; case inequality so an unknown never matches.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got,
				exp);
		end
	endtask

	// Waits n edges, then lets their updates settle before sampling.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Counts ticks and pin toggles over a window that every period divides.
	task automatic count_win(input int n);
		cnt = '{0, 0, 0, 0, 0, 0, 0};
		tog_b = 0;
		tog_m = 0;
		pb = bus_pin;
		pm = mem_pin;
		repeat (n) begin
			cyc(1);
			for (int i = 0; i < 7; i++) if (tk[i] === 1'b1) cnt[i]++;
			if (bus_pin !== pb) tog_b++;
			if (mem_pin !== pm) tog_m++;
			pb = bus_pin;
			pm = mem_pin;
		end
	endtask

	// One wait instruction pulse with the given mode selected.
	task automatic enter(input logic [1:0] m);
		@(posedge clk_i);
		mode_sel <= m;
		wait_x <= 1'b1;
		@(posedge clk_i);
		wait_x <= 1'b0;
		#1;
	endtask

	// Toggles a deep wake pin at a clock edge.
	task automatic flip(input int i);
		@(posedge clk_i);
		wpin[i] <= ~wpin[i];
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("errors %0d check_count %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog sized well beyond the fewer than one thousand cycles the tests take.
	initial begin
		#400000;
		errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		wrap_up();
	end

	// Main sequence.
	initial begin
		cyc(8);
		chk({en[0], en[1], en[2]} == 96'h0, 1, "enables after reset");
		chk({bus_pin, mem_pin, st, wflag, rcause}, 21'h180000, "reset");
		@(posedge clk_i);
		rst_b_i <= 1'b1;
		// One peripheral at a time is stopped; all others must keep running.
		for (int j = 0; j < 14; j++) begin
			@(posedge clk_i);
			for (int r = 0; r < 3; r++)
				stp[r] <= (r == regs[j]) ? 32'h1 << bits[j] : 32'h0;
			cyc(4);
			for (int r = 0; r < 3; r++)
				chk(en[r], r == regs[j] ? ~(32'h1 << bits[j]) : 32'hFFFFFFFF,
					"stop map");
		end
		@(posedge clk_i);
		// Network stop bits settle here, long before any wait instruction.
		stp <= '{32'h0, 32'h0, 32'h0};
		// Each clock gets its own ratio; the window is a multiple of all.
		@(posedge clk_i);
		for (int i = 0; i < 7; i++) sel[i] <= i[3:0];
		cyc(200);
		count_win(128);
		for (int i = 0; i < 7; i++) chk(cnt[i], 128 >> i, "ratio");
		chk(tog_b, 4, "bus pin toggles");
		chk(tog_m, 4, "mem pin toggles");
		@(posedge clk_i);
		bus_hh <= 1'b1;
		mem_hh <= 1'b1;
		sel[0] <= 4'hF;
		cyc(200);
		count_win(128);
		chk(cnt[0], 2, "clamped ratio");
		chk(tog_b + tog_m, 0, "held pins still");
		chk({bus_pin, mem_pin}, 2'h3, "held pins high");
		// Operating power modes; code three must leave the mode alone.
		for (int v = 0; v < 4; v++) begin
			@(posedge clk_i);
			opm <= v[1:0];
			cyc(3);
			chk(opm_o, v == 3 ? 2 : v, "op mode");
			chk(low_o, v != 0, "low speed");
		end
		// Voltage-monitor reset flags land at bits 1 to 3.
		for (int v = 0; v < 3; v++) begin
			@(posedge clk_i);
			vmon <= 3'h1 << v;
			@(posedge clk_i);
			vmon <= 3'h0;
			cyc(2);
			chk(rcause, 8'h2 << v, "reset cause");
			@(posedge clk_i);
			rclr <= 8'hFF;
			@(posedge clk_i);
			rclr <= 8'h00;
			cyc(2);
			chk(rcause, 0, "reset cause clear");
		end
		// A clear in the cycle of a new cause loses to the set.
		@(posedge clk_i);
		vmon <= 3'h4;
		rclr <= 8'hFF;
		@(posedge clk_i);
		vmon <= 3'h0;
		rclr <= 8'h00;
		cyc(2);
		chk(rcause, 8'h08, "set beats clear");
		// Sleep, all-module stop and software standby, each woken by irq.
		for (int m = 0; m < 3; m++) begin
			enter(m[1:0]);
			chk(st, m == 0 ? 1 : (m == 1 ? 3 : 2), "mode state");
			chk(cpu_h, 1, "cpu halted");
			cyc(3);
			chk(en[0], m > 0 ? 0 : 32'hFFFFFFFF, "module clocks");
			chk({per_h, osc_s}, m == 0 ? 0 : m + 1, "halt levels");
			enter(2'h2);
			chk(st, m == 0 ? 1 : (m == 1 ? 3 : 2), "wait refused");
			@(posedge clk_i);
			wake <= 1'b1;
			@(posedge clk_i);
			wake <= 1'b0;
			cyc(1);
			chk(st, 0, "woken");
		end
		// Deep standby per wake pin; cut codes walk through 0, 1, 2, 3.
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			if (i == 0) wen <= 8'hE0;
			cut <= i[1:0];
			wclr <= 8'hFF;
			@(posedge clk_i);
			wclr <= 8'h00;
			enter(2'h3);
			cyc(2);
			chk(st, 6, "deep");
			chk({per_h, osc_s, cpu_h}, 3'h7, "deep halts");
			chk(cut_o, i == 2 ? 1 : i, "cut kept");
			chk(ram_off, i != 0, "ram power");
			chk({vdet, por_lp}, i == 3 ? 2'h3 : 2'h0, "detector stop");
			if (i == 0) begin
				@(posedge clk_i);
				wake <= 1'b1;
				@(posedge clk_i);
				wake <= 1'b0;
				flip(0);
				cyc(12);
				chk(st, 6, "disabled pin and irq ignored");
				flip(0);
				@(posedge clk_i);
				wen <= 8'hF0;
				cyc(12);
				chk(st, 6, "unselected edge ignored");
			end
			flip(i);
			for (k = 0; k < 12 && rel !== 1'b1; k++) cyc(1);
			chk(rel, 1, "release pulse");
			cyc(1);
			chk(rel, 0, "release one cycle");
			chk(st, 0, "back to run");
			chk(wflag, 8'h10 << i, "wake flag");
		end
		wrap_up();
	end
endmodule
